// [fzr_pkg.sv]
// Purpose: Shared constants and types for the fault zone pin response block
// Assumes: 100 MHz clock, command layer delivers decoded byte commands
// Notes:   Command codes below are local choices for this block
`default_nettype none

package fzr_pkg;

  localparam int CLK_MHZ    = 100;
  localparam int CLK_PER_NS = 1000 / CLK_MHZ;

  // Fault line qualification time, in ns, and its cycle count (least time)
  localparam int QUAL_NS  = 10000;
  localparam int QUAL_CYC = (QUAL_NS + CLK_PER_NS - 1) / CLK_PER_NS;
  localparam int QUAL_W   = $clog2(QUAL_CYC + 1);

  localparam int NUM_CHAN  = 8;
  localparam int NUM_LINE  = 4;
  localparam int ZONE_CHAN = 4;
  localparam int TON_W     = 16;

  // Command codes of the registers
  localparam logic [7:0] CMD_Z0_LINE_A_SEL = 8'hE0;
  localparam logic [7:0] CMD_Z0_LINE_B_SEL = 8'hE1;
  localparam logic [7:0] CMD_Z1_LINE_A_SEL = 8'hE2;
  localparam logic [7:0] CMD_Z1_LINE_B_SEL = 8'hE3;
  localparam logic [7:0] CMD_OV_INEN_SEL   = 8'hE4;
  localparam logic [7:0] CMD_LINE_STATUS   = 8'hE5;

  // Field layout and reset values
  localparam int         SEL_FIELD_W    = 4;
  localparam logic [7:0] SEL_RESET      = 8'h00;
  localparam logic [7:0] OV_SEL_RESET   = 8'h00;
  localparam logic [7:0] READ_UNMAPPED  = 8'h00;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] code;
    logic [7:0] data;
  } fzr_cmd_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } fzr_rsp_s;

  typedef enum logic [1:0] {
    FZR_RUN,
    FZR_HELD,
    FZR_DELAY,
    FZR_RISE
  } fzr_chan_e;

endpackage

`default_nettype wire

// [fzr_fault_zone_response.sv]
// Purpose: Channel shutdown and restart on the shared open-drain fault lines
// Assumes: Lines 0,1 serve zone 0 (ch 0-3); lines 2,3 serve zone 1 (ch 4-7)
// Notes:   Turn-on delay and rise counts arrive in clock cycles per channel
`default_nettype none

module fzr_fault_zone_response
  import fzr_pkg::*;
#(
  parameter int QUAL_CYCLES = QUAL_CYC
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Command port from the serial command layer
  input  wire fzr_cmd_s              cmd,
  output var  fzr_rsp_s              rsp,
  // Shared open-drain fault lines, low is asserted
  input  wire logic [NUM_LINE-1:0]   fault_line_in,
  output var  logic [NUM_LINE-1:0]   fault_line_out,
  output var  logic [NUM_LINE-1:0]   fault_line_oe,
  // Propagation enables per line and faulted-off state per channel
  input  wire logic [NUM_LINE-1:0]   line_propagation_enable,
  input  wire logic [NUM_CHAN-1:0]   chan_faulted_off,
  // Channel on requests and restart timing
  input  wire logic [NUM_CHAN-1:0]   chan_on_req,
  input  wire logic [NUM_CHAN-1:0][TON_W-1:0] turn_on_delay,
  input  wire logic [NUM_CHAN-1:0][TON_W-1:0] turn_on_rise_time,
  output var  logic [NUM_CHAN-1:0]   chan_enable,
  output var  logic [NUM_CHAN-1:0]   chan_rising,
  // Overvoltage to input enable
  input  wire logic [NUM_CHAN-1:0]   output_overvoltage_fault,
  output var  logic                  input_enable_out,
  output var  logic                  input_enable_oe,
  // Alert and status
  input  wire logic [NUM_CHAN-1:0]   line_status_clear,
  output var  logic [NUM_CHAN-1:0]   line_shutdown_status,
  output var  logic                  alert_out_n
);

  localparam int QW = $clog2(QUAL_CYCLES + 1);

  logic [NUM_LINE-1:0][SEL_FIELD_W-1:0] line_sel;
  logic [NUM_CHAN-1:0]                  ov_input_enable_select;
  logic [NUM_LINE-1:0]                  sync_a;
  logic [NUM_LINE-1:0]                  sync_b;
  logic [NUM_LINE-1:0][QW-1:0]          qual_cnt;
  logic [NUM_LINE-1:0]                  line_qualified;
  logic [NUM_CHAN-1:0]                  chan_held;
  logic [NUM_CHAN-1:0]                  shut_event;
  logic [NUM_CHAN-1:0]                  next_status;
  logic [7:0]                           rd_mux;
  logic                                 wr_line;
  logic [1:0]                           wr_idx;
  logic                                 ov_pull;
  logic [NUM_LINE-1:0]                  next_line_drive;

  // Command decode
  assign wr_line = cmd.wr && (cmd.code >= CMD_Z0_LINE_A_SEL)
                   && (cmd.code <= CMD_Z1_LINE_B_SEL);
  assign wr_idx  = 2'(cmd.code - CMD_Z0_LINE_A_SEL);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      line_sel               <= '0;
      ov_input_enable_select <= OV_SEL_RESET;
    end else begin
      if (wr_line) begin
        // Upper nibble dropped: it does not exist
        line_sel[wr_idx] <= cmd.data[SEL_FIELD_W-1:0];
      end
      if (cmd.wr && cmd.code == CMD_OV_INEN_SEL) begin
        ov_input_enable_select <= cmd.data;
      end
    end
  end

  // Readback, reserved bits zero-filled
  always_comb begin
    rd_mux = READ_UNMAPPED;
    unique case (cmd.code)
      CMD_Z0_LINE_A_SEL: rd_mux = {4'h0, line_sel[0]};
      CMD_Z0_LINE_B_SEL: rd_mux = {4'h0, line_sel[1]};
      CMD_Z1_LINE_A_SEL: rd_mux = {4'h0, line_sel[2]};
      CMD_Z1_LINE_B_SEL: rd_mux = {4'h0, line_sel[3]};
      CMD_OV_INEN_SEL:   rd_mux = ov_input_enable_select;
      CMD_LINE_STATUS:   rd_mux = line_shutdown_status;
      default:           rd_mux = READ_UNMAPPED;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsp <= '0;
    end else begin
      rsp.valid <= cmd.rd;
      rsp.data  <= cmd.rd ? rd_mux : 8'h00;
    end
  end

  // Pins come from outside: two flops before any use
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_a <= '1;
      sync_b <= '1;
    end else begin
      sync_a <= fault_line_in;
      sync_b <= sync_a;
    end
  end

  // Qualification: count while low, restart on release
  genvar l;
  generate
    for (l = 0; l < NUM_LINE; l++) begin : g_line
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          qual_cnt[l] <= '0;
        end else if (sync_b[l]) begin
          qual_cnt[l] <= '0;
        end else if (qual_cnt[l] != QW'(QUAL_CYCLES)) begin
          qual_cnt[l] <= qual_cnt[l] + QW'(1);
        end
      end
      assign line_qualified[l] = (qual_cnt[l] == QW'(QUAL_CYCLES));
      // Any faulted-off channel of the zone pulls when enabled
      assign next_line_drive[l] = line_propagation_enable[l]
          && |chan_faulted_off[(l/2)*ZONE_CHAN +: ZONE_CHAN];
    end
  endgenerate

  // Zone line pair feeds its four channels, bit k to channel k of zone
  genvar c;
  generate
    for (c = 0; c < NUM_CHAN; c++) begin : g_chan
      localparam int Z = c / ZONE_CHAN;
      localparam int K = c % ZONE_CHAN;
      fzr_chan_e          st;
      fzr_chan_e          next_st;
      logic [TON_W-1:0]   cnt;
      logic               cnt_done;

      // Either qualified line of the zone whose select bit k is set holds the channel off
      assign chan_held[c] =
          (line_qualified[2*Z]   && line_sel[2*Z][K])   ||
          (line_qualified[2*Z+1] && line_sel[2*Z+1][K]);
      assign cnt_done = (cnt == '0);

      always_comb begin
        next_st = st;
        unique case (st)
          FZR_RUN:   if (chan_held[c] && chan_on_req[c]) next_st = FZR_HELD;
          FZR_HELD:  if (!chan_held[c]) next_st = FZR_DELAY;
          FZR_DELAY: if (chan_held[c]) next_st = FZR_HELD;
                     else if (cnt_done) next_st = FZR_RISE;
          FZR_RISE:  if (chan_held[c]) next_st = FZR_HELD;
                     else if (cnt_done) next_st = FZR_RUN;
        endcase
      end

      assign shut_event[c] = (next_st == FZR_HELD) && (st != FZR_HELD);

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          st  <= FZR_RUN;
          cnt <= '0;
        end else begin
          st <= next_st;
          if (st == FZR_HELD) begin
            cnt <= turn_on_delay[c];
          end else if (st == FZR_DELAY && cnt_done) begin
            cnt <= turn_on_rise_time[c];
          end else if (!cnt_done) begin
            cnt <= cnt - TON_W'(1);
          end
        end
      end

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          chan_enable[c] <= 1'b0;
          chan_rising[c] <= 1'b0;
        end else begin
          chan_enable[c] <= chan_on_req[c]
                            && (next_st == FZR_RUN || next_st == FZR_RISE);
          chan_rising[c] <= chan_on_req[c] && next_st == FZR_RISE;
        end
      end
    end
  endgenerate

  // Set wins over a clear in the same cycle
  assign next_status = (line_shutdown_status & ~line_status_clear)
                       | shut_event;
  assign ov_pull     = |(output_overvoltage_fault & ov_input_enable_select);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      line_shutdown_status <= '0;
      alert_out_n          <= 1'b1;
      input_enable_out     <= 1'b0;
      input_enable_oe      <= 1'b0;
      fault_line_out       <= '0;
      fault_line_oe        <= '0;
    end else begin
      line_shutdown_status <= next_status;
      alert_out_n          <= ~|next_status;
      // Pull-down only; single flop keeps the response fast
      input_enable_out     <= 1'b0;
      input_enable_oe      <= ov_pull;
      fault_line_out       <= '0;
      fault_line_oe        <= next_line_drive;
    end
  end

endmodule

`default_nettype wire

// [fzr_props.sv]
// Purpose: Port checks for the fault zone response block
// Assumes: One clock, async active-high reset
// Notes:   Low on a fault line means asserted
`default_nettype none
module fzr_props
  import fzr_pkg::*;
#(parameter int QUAL_CYCLES = QUAL_CYC) (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // Commands
  input wire fzr_cmd_s   cmd,
  input wire fzr_rsp_s   rsp,
  // Lines and channels
  input wire logic [3:0] fault_line_in,
  input wire logic [3:0] fault_line_oe,
  input wire logic [3:0] line_propagation_enable,
  input wire logic [7:0] chan_faulted_off,
  input wire logic [7:0] chan_on_req,
  input wire logic [7:0] chan_enable,
  input wire logic [7:0] chan_rising,
  input wire logic [7:0] output_overvoltage_fault,
  input wire logic       input_enable_oe,
  input wire logic [7:0] line_shutdown_status,
  input wire logic       alert_out_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Cycles since every line was last released, saturating
  logic [15:0] low_run;
  always_ff @(posedge clk or posedge rst)
    if (rst) low_run <= '0;
    else if (fault_line_in == 4'hF) low_run <= '0;
    else if (low_run != 16'hFFFF) low_run <= low_run + 16'h0001;
  property p_qual;
    |(line_shutdown_status & ~$past(line_shutdown_status))
      |-> low_run >= QUAL_CYCLES;
  endproperty
  a_qual: assert property (p_qual) else $error("short pulse shut");
  property p_stat_en;
    ((line_shutdown_status & ~$past(line_shutdown_status)) & chan_enable)
      == 8'h00;
  endproperty
  a_stat_en: assert property (p_stat_en) else $error("status, on");
  property p_alert;
    alert_out_n == ~|line_shutdown_status;
  endproperty
  a_alert: assert property (p_alert) else $error("alert wrong");
  property p_resv;
    rsp.valid && $past(cmd.code[7:2]) == CMD_Z0_LINE_A_SEL[7:2]
      |-> rsp.data[7:4] == 4'h0;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved set");
  property p_rd;
    1'b1 |=> rsp.valid == $past(cmd.rd);
  endproperty
  a_rd: assert property (p_rd) else $error("read answer");
  property p_ov;
    !(|output_overvoltage_fault) |=> !input_enable_oe;
  endproperty
  a_ov: assert property (p_ov) else $error("input enable pulled");
  property p_prop0;
    1'b1 |=> fault_line_oe[0] ==
      $past(line_propagation_enable[0] & (|chan_faulted_off[3:0]));
  endproperty
  a_prop0: assert property (p_prop0) else $error("zone 0 pull");
  property p_rise;
    (chan_rising & chan_on_req & ~chan_enable) == 8'h00;
  endproperty
  a_rise: assert property (p_rise) else $error("rise, off");
  c_read: cover property (rsp.valid);
  c_shut: cover property ($fell(alert_out_n));
  c_ov: cover property (input_enable_oe);
endmodule
bind fzr_fault_zone_response fzr_props #(.QUAL_CYCLES(QUAL_CYCLES)) u_props (
  .clk, .rst, .cmd, .rsp, .fault_line_in, .fault_line_oe,
  .line_propagation_enable, .chan_faulted_off, .chan_on_req, .chan_enable,
  .chan_rising, .output_overvoltage_fault, .input_enable_oe,
  .line_shutdown_status, .alert_out_n);
`default_nettype wire

// [fzr_line_partner.sv]
// Purpose: Other managers sharing the open-drain fault lines
// Assumes: Lines pulled up when nobody pulls
// Notes:   Wired-AND of far pulls and our pull-downs
`default_nettype none
module fzr_line_partner (
  // Pull requests
  input  wire logic [3:0] far_pull,
  input  wire logic [3:0] near_oe,
  // Resolved lines
  output var  logic [3:0] line
);
  timeunit 1ns;
  timeprecision 1ps;
  assign line = ~(far_pull | near_oe);
endmodule
`default_nettype wire

// [test_fault_zone_pin_response.sv]
// Purpose: Self-checking bench for the fault zone response block
// Assumes: Short qualification count keeps the run brief
// Notes:   Delay 3 and rise 2 cycles on every channel
`default_nettype none
module test_fault_zone_pin_response
  import fzr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int QC = 20;
  logic       clk, rst, ie_oe, alert_n;
  fzr_cmd_s   cmd;
  fzr_rsp_s   rsp;
  logic [3:0] line, pull, foe, prop;
  logic [7:0] off, ov, clr, stat, en, rise, onr;
  logic [3:0] fout;
  logic       ie_out;
  int         num_errors = 0, checked = 0, cyc = 0;
  fzr_fault_zone_response #(.QUAL_CYCLES(QC)) u_dut (
    .clk(clk), .rst(rst), .cmd(cmd), .rsp(rsp), .fault_line_in(line),
    .fault_line_out(fout), .fault_line_oe(foe),
    .line_propagation_enable(prop),
    .chan_faulted_off(off), .chan_on_req(onr),
    .turn_on_delay({8{16'h0003}}), .turn_on_rise_time({8{16'h0002}}),
    .chan_enable(en), .chan_rising(rise), .output_overvoltage_fault(ov),
    .input_enable_out(ie_out), .input_enable_oe(ie_oe),
    .line_status_clear(clr),
    .line_shutdown_status(stat), .alert_out_n(alert_n));
  fzr_line_partner u_far (.far_pull(pull), .near_oe(foe), .line(line));
  task automatic chk(input logic [8:0] got, exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] c, d);
    @(negedge clk) cmd <= '{1'b1, 1'b0, c, d};
    @(negedge clk) cmd <= '0;
  endtask
  task automatic rd(input logic [7:0] c, e);
    @(negedge clk) cmd <= '{1'b0, 1'b1, c, 8'h00};
    @(negedge clk) cmd <= '0;
    for (int i = 0; i < 3 && rsp.valid !== 1'b1; i++) @(negedge clk);
    chk(rsp, {1'b1, e});
  endtask
  task automatic hold(input logic [3:0] m, input int n);
    @(negedge clk) pull <= m;
    repeat (n) @(negedge clk);
  endtask
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Run needs about 220 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  initial begin
    rst = 1'b1;
    {cmd, pull, prop, off, ov, clr} = '0;
    onr = 8'hFF;
    repeat (6) @(posedge clk);
    @(negedge clk) rst <= 1'b0;
    for (int k = 0; k < 8; k++) rd(8'hE0 + k[7:0], 8'h00);
    wr(CMD_Z0_LINE_A_SEL, 8'hF5);
    wr(CMD_Z0_LINE_B_SEL, 8'h01);
    wr(CMD_Z1_LINE_A_SEL, 8'h08);
    rd(CMD_Z0_LINE_A_SEL, 8'h05);
    hold(4'h1, QC / 2);
    hold(4'h0, 4);
    chk(stat, 8'h00);
    hold(4'h3, QC + 10);
    chk({alert_n, stat}, 9'h005);
    chk(en, 8'hFA);
    // Line b still low keeps channel 0 off; channel 2 restarts
    hold(4'h2, 15);
    chk(en, 8'hFE);
    hold(4'h0, 4);
    chk(en, 8'hFE);
    for (int i = 0; i < 20 && rise[0] !== 1'b1; i++) @(negedge clk);
    chk({rise[0], en}, 9'h1FF);
    @(negedge clk) clr <= 8'hFF;
    @(negedge clk) clr <= 8'h00;
    @(negedge clk) chk({alert_n, stat}, 9'h100);
    hold(4'hC, QC + 10);
    chk({en[7], stat}, 9'h080);
    hold(4'h0, 20);
    chk(en, 8'hFF);
    // Channel 2 not requested on: a qualified line must not hold it
    onr <= 8'hFB;
    hold(4'h1, QC + 10);
    chk({alert_n, stat}, 9'h081);
    chk(en, 8'hFA);
    hold(4'h0, 20);
    onr <= 8'hFF;
    wr(CMD_OV_INEN_SEL, 8'h10);
    @(negedge clk) ov <= 8'h08;
    @(negedge clk) chk(ie_oe, 1'b0);
    ov <= 8'h10;
    @(negedge clk) chk(ie_oe, 1'b1);
    {ov, prop, off} <= {8'h00, 4'h1, 8'h12};
    @(negedge clk) chk({foe, line}, 8'h1E);
    chk({fout, ie_out}, 9'h000);
    {prop, off} <= '0;
    tally_and_finish();
  end
endmodule
`default_nettype wire
